/* logic/dccs_ctrl.sv */
// Channel control and sync register bank with sync-driven updates
// How it works
// - Fixed gain selected shifts mixer by shift
// - Fixed gain low uses input exponent shift
// - Hold bit keeps channel reset, clock off
// - Channel register powers up as 0x80
// - Phase applies on low tuning selector sync
// - Frequency applies on high tuning selector sync
// - Always selection applies phase/frequency at once
// - Oscillator sync loads accumulator with phase
// - Dither sync clears dither generator
// - Never keeps dither, always holds zero
// - Pad count zeros inserted between samples
// - Pad timing from selected sync source
// - Padding only while enable bit set
// - Decimation sync resyncs decimation counter
// - Periodic resync with 8N period harmless
// - Flush sync flushes datapath 24N clocks
// - Twelve bit ratio over two bytes
// - Fine gain applies on ratio-high selector sync
// - Terminal count every 256(count+1) clocks
// - Mixer rounds 20 bits when wide, else 16
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module dccs_ctrl #(
    parameter int CNT_W = 8                   // Sync count setting width
) (
    input wire logic i_clk,                    // Chip clock, 100 MHz
    input wire logic i_rstn,                   // Async reset, active low
    input wire dccs_pkg::dccs_bus_req_t i_bus, // Register bus request
    output logic [7:0] o_rdata,                // Read data, cycle after
    input wire dccs_pkg::dccs_sync_src_t i_src, // Shared sync sources
    input wire logic [CNT_W-1:0] i_tc_count,   // Sync counter setting
    input wire logic i_wide_mixer_round,       // 20-bit mixer rounding
    input wire logic i_real_only_ganged_mode,  // Split real mode flag
    input wire logic [2:0] i_sample_exp,       // Input exponent bits
    output logic o_channel_hold,               // Channel held in reset
    output logic o_clk_en,                     // Channel clock enable
    output logic [2:0] o_mix_shift,            // Mixer up-shift amount
    output logic [4:0] o_round_bits,           // 20 or 16 bit rounding
    output logic o_terminal_count_pulse,       // Sync counter wrap
    output logic [3:0] o_pad_count,            // Zeros between samples
    output logic o_padding_on,                 // Zero padding active
    output logic [11:0] o_rate_ratio,          // Decimation control
    output logic o_flush,                      // Datapath flushing
    output dccs_pkg::dccs_upd_t o_upd          // Update pulses
);
    import dccs_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam int FLUSH_W = 17;   // Holds 24 * 4096 clocks
    localparam int TC_W = CNT_W + 8;  // Sync counter width

    typedef struct packed {
        logic [7:0] chreset;       // Reset and gain shift
        logic [7:0] tunsel;        // Phase/freq update select
        logic [7:0] oscsel;        // Oscillator/dither select
        logic [7:0] zpad;          // Zero pad control
        logic [7:0] decsel;        // Decimation/flush select
        logic [7:0] ratlo;         // Ratio low byte
        logic [7:0] rathi;         // Ratio high byte
        logic [7:0] rdata;         // Read data register
        logic [TC_W-1:0] tc_cnt;   // Sync counter
        logic tc;                  // Terminal count pulse
        logic [FLUSH_W-1:0] flush_cnt;  // Flush clocks left
        logic [2:0] shift;         // Chosen mixer shift
        dccs_upd_t upd;            // Registered update pulses
    } dccs_state_t;

    dccs_state_t st_r;   // Registered state
    dccs_state_t st_nxt; // Next state

    // Source vector indexed by selector code
    logic [7:0] src_vec;
    // Selector outputs
    logic [7:0] fire;
    // Selector codes, one per function
    logic [7:0][2:0] sel;
    // Flush length for current ratio
    logic [FLUSH_W-1:0] flush_len;

    // ------------------------------------------------------------
    // Sync sources
    // ------------------------------------------------------------
    // eight shared sources
    always_comb begin
        src_vec = 8'h00;
        src_vec[DCCS_SYNC_NEVER] = 1'b0;
        src_vec[DCCS_SYNC_SIA] = i_src.ext_a;
        src_vec[DCCS_SYNC_SIB] = i_src.ext_b;
        src_vec[DCCS_SYNC_ONE] = i_src.one_shot;
        src_vec[DCCS_SYNC_TWO] = i_src.aux1;
        src_vec[DCCS_SYNC_TC] = st_r.tc;
        src_vec[DCCS_SYNC_THREE] = i_src.aux2;
        src_vec[DCCS_SYNC_ALWAYS] = 1'b1;
    end

    // Selector fields: phase, freq, osc, dither, pad, dec, flush, gain
    assign sel[0] = st_r.tunsel[DCCS_LO_SEL_LSB +: 3];
    assign sel[1] = st_r.tunsel[DCCS_HI_SEL_LSB +: 3];
    assign sel[2] = st_r.oscsel[DCCS_LO_SEL_LSB +: 3];
    assign sel[3] = st_r.oscsel[DCCS_HI_SEL_LSB +: 3];
    assign sel[4] = st_r.zpad[DCCS_HI_SEL_LSB +: 3];
    assign sel[5] = st_r.decsel[DCCS_LO_SEL_LSB +: 3];
    assign sel[6] = st_r.decsel[DCCS_HI_SEL_LSB +: 3];
    assign sel[7] = st_r.rathi[DCCS_HI_SEL_LSB +: 3];

    // One selector instance per sync function
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pick
            dccs_sync_pick u_pick (
                .i_clk(i_clk),
                .i_rstn(i_rstn),
                .i_sel(sel[g]),
                .i_src(src_vec),
                .o_fire(fire[g])
            );
        end
    endgenerate

    // Flush length 24N; N = field + 1, or half that in ganged mode
    // Ganged fields hold 2N minus one, so the halving is always exact
    // flush 24N clocks
    assign flush_len = (FLUSH_W'(DCCS_FLUSH_MULT)
        * (FLUSH_W'(st_r.ratlo) + (FLUSH_W'(st_r.rathi[3:0]) << 8) + 1'b1))
        >> i_real_only_ganged_mode;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Bus writes; no wait states, unused bits store as written
        if (i_bus.wr) begin
            case (i_bus.addr)
                DCCS_OFS_CHRESET: st_nxt.chreset = i_bus.wdata;
                DCCS_OFS_TUNSEL: st_nxt.tunsel = i_bus.wdata;
                DCCS_OFS_OSCSEL: st_nxt.oscsel = i_bus.wdata;
                DCCS_OFS_ZPAD: st_nxt.zpad = i_bus.wdata;
                DCCS_OFS_DECSEL: st_nxt.decsel = i_bus.wdata;
                DCCS_OFS_RATLO: st_nxt.ratlo = i_bus.wdata;
                DCCS_OFS_RATHI: st_nxt.rathi = i_bus.wdata;
                default: ;
            endcase
        end
        // Reads: data valid the cycle after, unmapped reads zero
        if (i_bus.rd) begin
            case (i_bus.addr)
                DCCS_OFS_CHRESET: st_nxt.rdata = st_r.chreset;
                DCCS_OFS_TUNSEL: st_nxt.rdata = st_r.tunsel;
                DCCS_OFS_OSCSEL: st_nxt.rdata = st_r.oscsel;
                DCCS_OFS_ZPAD: st_nxt.rdata = st_r.zpad;
                DCCS_OFS_DECSEL: st_nxt.rdata = st_r.decsel;
                DCCS_OFS_RATLO: st_nxt.rdata = st_r.ratlo;
                DCCS_OFS_RATHI: st_nxt.rdata = st_r.rathi;
                default: st_nxt.rdata = 8'h00;
            endcase
        end else begin
            st_nxt.rdata = 8'h00;
        end

        if (st_r.tc_cnt >= ((TC_W'(i_tc_count) + 1'b1) << 8) - 1'b1) begin
            st_nxt.tc_cnt = '0;
            st_nxt.tc = 1'b1;
        end else begin
            st_nxt.tc_cnt = st_r.tc_cnt + 1'b1;
            st_nxt.tc = 1'b0;
        end

        if (st_r.chreset[DCCS_FIXED_BIT]) begin
            st_nxt.shift = st_r.chreset[2:0];
        end else begin
            st_nxt.shift = i_sample_exp;
        end

        // phase on its sync; frequency on its sync
        // always code fires every cycle, so writes apply at once
        st_nxt.upd.phase_load = fire[0];
        st_nxt.upd.freq_load = fire[1];
        st_nxt.upd.osc_init = fire[2];
        // dither cleared; always keeps it held at zero
        st_nxt.upd.dither_clr = fire[3];
        st_nxt.upd.pad_sync = fire[4];
        // decimation counter resync; periodic is harmless
        st_nxt.upd.dec_sync = fire[5];
        st_nxt.upd.gain_load = fire[7];

        if (fire[6]) begin
            st_nxt.flush_cnt = flush_len;
        end else if (st_r.flush_cnt != '0) begin
            st_nxt.flush_cnt = st_r.flush_cnt - 1'b1;
        end

        // channel hold also clears channel-side sync state
        if (st_r.chreset[DCCS_HOLD_BIT]) begin
            st_nxt.upd = '0;
            st_nxt.flush_cnt = '0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // channel starts held
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r <= '0;
            st_r.chreset <= DCCS_RST_CHRESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata = st_r.rdata;
    assign o_channel_hold = st_r.chreset[DCCS_HOLD_BIT];
    assign o_clk_en = !st_r.chreset[DCCS_HOLD_BIT];
    assign o_mix_shift = st_r.shift;
    assign o_round_bits = i_wide_mixer_round ? 5'h14 : 5'h10;
    assign o_terminal_count_pulse = st_r.tc;
    assign o_pad_count = st_r.zpad[3:0];
    assign o_padding_on = st_r.zpad[DCCS_PADON_BIT];
    assign o_rate_ratio = {st_r.rathi[3:0], st_r.ratlo};
    assign o_flush = st_r.flush_cnt != '0;
    assign o_upd = st_r.upd;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_reset_write;
        i_bus.wr && i_bus.addr == DCCS_OFS_CHRESET;
    endsequence

    property p_fixed_shift;
        @(posedge i_clk) disable iff (!i_rstn)
        (st_r.chreset[3] && !i_bus.wr) ##1 1'b1
            |-> o_mix_shift == $past(st_r.chreset[2:0]);
    endproperty
    a_fixed_shift: assert property (p_fixed_shift)
        else $error("fixed shift not applied");

    property p_exp_shift;
        @(posedge i_clk) disable iff (!i_rstn)
        !st_r.chreset[3] |=> o_mix_shift == $past(i_sample_exp);
    endproperty
    a_exp_shift: assert property (p_exp_shift)
        else $error("exponent shift not applied");

    // held channel quiet
    // Pulses launched in the cycle the hold is set may still show once
    property p_hold_clk;
        @(posedge i_clk) disable iff (!i_rstn)
        o_channel_hold && $past(o_channel_hold)
            |-> !o_clk_en && o_upd == '0 && !o_flush;
    endproperty
    a_hold_clk: assert property (p_hold_clk)
        else $error("held channel active");

    property p_read_back;
        @(posedge i_clk) disable iff (!i_rstn)
        s_reset_write ##1 (i_bus.rd && i_bus.addr == DCCS_OFS_CHRESET
            && !i_bus.wr) |=> o_rdata == $past(i_bus.wdata, 2);
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("channel register readback wrong");

    property p_freq_always;
        @(posedge i_clk) disable iff (!i_rstn)
        (sel[1] == 3'h7 && !o_channel_hold) |=> o_upd.freq_load;
    endproperty
    a_freq_always: assert property (p_freq_always)
        else $error("always did not load frequency");

    property p_dither_never;
        @(posedge i_clk) disable iff (!i_rstn)
        sel[3] == 3'h0 |=> !o_upd.dither_clr;
    endproperty
    a_dither_never: assert property (p_dither_never)
        else $error("dither cleared under never");

    property p_flush_len;
        @(posedge i_clk) disable iff (!i_rstn)
        (fire[6] && !o_channel_hold) |=> o_flush
            && st_r.flush_cnt == $past(flush_len);
    endproperty
    a_flush_len: assert property (p_flush_len)
        else $error("flush length wrong");

    property p_tc_gap;
        @(posedge i_clk) disable iff (!i_rstn)
        o_terminal_count_pulse |=> !o_terminal_count_pulse [*8];
    endproperty
    a_tc_gap: assert property (p_tc_gap)
        else $error("terminal count too early");

    property p_phase_ext;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_src.ext_a && sel[0] == DCCS_SYNC_SIA && !o_channel_hold)
            |=> o_upd.phase_load;
    endproperty
    a_phase_ext: assert property (p_phase_ext)
        else $error("phase sync missed");

    property p_osc_tc;
        @(posedge i_clk) disable iff (!i_rstn)
        (o_terminal_count_pulse && sel[2] == DCCS_SYNC_TC
            && !o_channel_hold) |=> o_upd.osc_init;
    endproperty
    a_osc_tc: assert property (p_osc_tc)
        else $error("counter wrap did not load accumulator");

    property p_flush_step;
        @(posedge i_clk) disable iff (!i_rstn)
        (o_flush && !fire[6] && !o_channel_hold)
            |=> st_r.flush_cnt == $past(st_r.flush_cnt) - 1'b1;
    endproperty
    a_flush_step: assert property (p_flush_step)
        else $error("flush count did not step");
endmodule
`default_nettype wire

/* common/dccs_pkg.sv */
// Package: register map, field layout, reset values and sync codes
package dccs_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses within the control page)
    // ------------------------------------------------------------
    localparam logic [7:0] DCCS_OFS_CHRESET = 8'h10;  // Reset and gain shift
    localparam logic [7:0] DCCS_OFS_TUNSEL = 8'h11;   // Phase/freq update select
    localparam logic [7:0] DCCS_OFS_OSCSEL = 8'h12;   // Oscillator/dither select
    localparam logic [7:0] DCCS_OFS_ZPAD = 8'h13;     // Zero pad control
    localparam logic [7:0] DCCS_OFS_DECSEL = 8'h14;   // Decimation/flush select
    localparam logic [7:0] DCCS_OFS_RATLO = 8'h15;    // Ratio low byte
    localparam logic [7:0] DCCS_OFS_RATHI = 8'h16;    // Ratio high, gain select

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DCCS_LO_SEL_LSB = 0;   // Low selector field
    localparam int DCCS_HI_SEL_LSB = 4;   // High selector field
    localparam int DCCS_FIXED_BIT = 3;    // Fixed gain select bit
    localparam int DCCS_HOLD_BIT = 7;     // Channel hold bit
    localparam int DCCS_PADON_BIT = 7;    // Padding enable bit

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DCCS_RST_CHRESET = 8'h80;  // Channel starts held
    localparam logic [7:0] DCCS_RST_OTHER = 8'h00;    // Other registers

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int DCCS_FLUSH_MULT = 24;  // Flush lasts 24N clocks
    localparam int DCCS_TC_UNIT = 256;    // Sync counter step
    localparam int DCCS_EXP_SHIFT_LSB = 0;  // Exponent bits in sample

    // ------------------------------------------------------------
    // Sync source codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DCCS_SYNC_NEVER = 3'h0,
        DCCS_SYNC_SIA = 3'h1,
        DCCS_SYNC_SIB = 3'h2,
        DCCS_SYNC_ONE = 3'h3,
        DCCS_SYNC_TWO = 3'h4,
        DCCS_SYNC_TC = 3'h5,
        DCCS_SYNC_THREE = 3'h6,
        DCCS_SYNC_ALWAYS = 3'h7
    } dccs_sync_sel_t;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;   // Byte address
        logic [7:0] wdata;  // Write data
        logic wr;           // Write strobe
        logic rd;           // Read strobe
    } dccs_bus_req_t;

    // Shared sync sources, one bit each for selector codes 1, 2, 3, 4 and 6
    typedef struct packed {
        logic ext_a;        // External sync A (pin)
        logic ext_b;        // External sync B (pin)
        logic one_shot;     // One shot sync
        logic aux1;         // Auxiliary source 1
        logic aux2;         // Auxiliary source 2
    } dccs_sync_src_t;

    // Update pulses to the channel datapath
    typedef struct packed {
        logic phase_load;   // Apply new phase offset
        logic freq_load;    // Apply new tuning frequency
        logic osc_init;     // Load accumulator with phase
        logic dither_clr;   // Hold dither at zero
        logic pad_sync;     // Zero pad timing sync
        logic dec_sync;     // Decimation counter resync
        logic gain_load;    // Apply new fine gain
    } dccs_upd_t;

endpackage

/* logic/dccs_sync_pick.sv */
// Sync selector: maps a 3-bit code onto one of eight shared sources
`timescale 1ns/1ns
`default_nettype none
module dccs_sync_pick (
    input wire logic i_clk,                    // Chip clock
    input wire logic i_rstn,                   // Async reset, active low
    input wire logic [2:0] i_sel,              // Selector code
    input wire logic [7:0] i_src,              // Sources by code
    output logic o_fire                        // Selected source pulse
);
    import dccs_pkg::*;

    // ------------------------------------------------------------
    // Selection
    // ------------------------------------------------------------
    // Code 0 is never and code 7 is always; caller ties those bits
    // code picks source
    assign o_fire = i_src[i_sel];

    property p_never_quiet;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_sel == 3'h0 && !i_src[0]) |-> !o_fire;
    endproperty
    a_never_quiet: assert property (p_never_quiet)
        else $error("never selection fired");
endmodule
`default_nettype wire

/* verif/dccs_tb.sv */
// Self-checking bench for the channel control and sync register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import dccs_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;             // Chip clock, 10 ns period
    logic rstn = 1'b0;            // Reset, active low
    dccs_bus_req_t bus = '0;      // Register bus request
    dccs_sync_src_t src = '0;     // Shared sync sources
    logic [7:0] tc_count = 8'h00; // Zero gives the shortest sync period
    logic wide_round = 1'b0;      // 20-bit mixer rounding
    logic ganged = 1'b0;          // Split real ganged mode
    logic [2:0] sample_exp = 3'h0; // Input exponent shift
    logic [7:0] rdata;            // Read data
    logic hold;                   // Channel held
    logic clk_en;                 // Channel clock enable
    logic [2:0] mix_shift;        // Mixer shift
    logic [4:0] round_bits;       // Rounding width
    logic tc_pulse;               // Sync counter wrap
    logic [3:0] pad_count;        // Zeros between samples
    logic pad_on;                 // Padding active
    logic [11:0] ratio;           // Decimation control
    logic flush;                  // Datapath flushing
    dccs_upd_t upd;               // Update pulses
    int mismatches = 0;           // Failed comparisons
    int comparisons = 0;          // All comparisons
    int n;                        // Cycle counter
    logic [1:0] seen;             // Oscillator and dither pulses seen
    // One source per entry, and the pulses its selectors must give
    dccs_sync_src_t srcs [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
    dccs_upd_t exps [5] = '{7'h42, 7'h21, 7'h10, 7'h08, 7'h04};
    logic [7:0] vals [7] = '{8'hF3, 8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h96, 8'h69};

    always #5 clk = ~clk;

    dccs_ctrl DUT (
        .i_clk(clk), .i_rstn(rstn), .i_bus(bus), .o_rdata(rdata),
        .i_src(src), .i_tc_count(tc_count), .i_wide_mixer_round(wide_round),
        .i_real_only_ganged_mode(ganged), .i_sample_exp(sample_exp),
        .o_channel_hold(hold), .o_clk_en(clk_en), .o_mix_shift(mix_shift),
        .o_round_bits(round_bits), .o_terminal_count_pulse(tc_pulse),
        .o_pad_count(pad_count), .o_padding_on(pad_on),
        .o_rate_ratio(ratio), .o_flush(flush), .o_upd(upd)
    );

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    // Compare any plain value, widened to twelve bits
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Compare the whole update pulse bundle
    task automatic chk_upd(input dccs_upd_t exp);
        chk({5'h00, upd}, {5'h00, exp});
    endtask
    // One-cycle write strobe; a gap cycle follows so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    // Write then read the same byte with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk({4'h0, rdata}, {4'h0, d});
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk({4'h0, rdata}, {4'h0, exp});
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // Source high for one edge; pulses are due just after that same edge
    task automatic pulse(input dccs_sync_src_t s, input dccs_upd_t e);
        @(posedge clk);
        src <= s;
        @(posedge clk);
        src <= '0;
        #1;
        chk_upd(e);
    endtask
    // Cycles the flush stays high, bounded; running out ends the run
    task automatic meas_flush(output int c);
        c = 0;
        while (flush === 1'b1 && c < 1000) begin
            c++;
            tick(1);
        end
        if (c >= 1000) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
            summarize();
        end
    endtask
    // Cycles to the next wrap of the sync counter, bounded
    task automatic wait_tc(output int c);
        c = 0;
        do begin
            tick(1);
            c++;
        end while (tc_pulse !== 1'b1 && c < 1100);
        if (c >= 1100) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            summarize();
        end
    endtask
    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        #1;
        chk(12'({hold, clk_en}), 12'h002); // held in reset
        rstn <= 1'b1;
        rd(DCCS_OFS_CHRESET, DCCS_RST_CHRESET); // power-up value
        for (int a = 8'h11; a <= 8'h16; a++) begin
            rd(8'(a), DCCS_RST_OTHER);
        end
        $display("test reset done");
        // Every byte, unused bits too, reads back while the channel is held
        for (int i = 0; i < 7; i++) begin
            wr(8'(8'h10 + i), vals[i]);
        end
        for (int i = 0; i < 7; i++) begin
            rd(8'(8'h10 + i), vals[i]);
        end
        wr_rd(DCCS_OFS_CHRESET, 8'h8B); // write and read back to back
        chk(ratio, 12'h996); // ratio over two bytes
        chk(12'({pad_count, pad_on}), 12'h018); // padding off
        wr(8'h17, 8'hFF);
        rd(8'h17, 8'h00);
        rd(8'h0F, 8'h00);
        $display("test readback done");
        // All selectors but flush on always, but the hold bit blocks every update
        wr(DCCS_OFS_TUNSEL, 8'h77);
        wr(DCCS_OFS_OSCSEL, 8'h77);
        wr(DCCS_OFS_ZPAD, 8'hFF);
        wr(DCCS_OFS_DECSEL, 8'h07);
        wr(DCCS_OFS_RATHI, 8'h70);
        tick(2);
        chk_upd(7'h00); // no updates while held
        chk(12'(flush), 12'h000); // no flush while held
        wr(DCCS_OFS_CHRESET, 8'h0C);
        tick(3);
        chk(12'({hold, clk_en}), 12'h001); // released
        chk_upd(7'h7F); // always applies at once
        chk(12'(mix_shift), 12'h004); // fixed shift
        chk(12'({pad_count, pad_on}), 12'h01F); // count and enable
        $display("test always done");
        // Exponent path when the fixed shift is not selected
        sample_exp <= 3'h6;
        wr(DCCS_OFS_CHRESET, 8'h05);
        tick(3);
        chk(12'(mix_shift), 12'h006); // exponent shift
        wide_round <= 1'b1; // 20-bit rounding, which does not depend on the shift setting
        tick(1);
        chk(12'(round_bits), 12'h014); // twenty bits
        wide_round <= 1'b0;
        tick(1);
        chk(12'(round_bits), 12'h010); // sixteen bits
        $display("test shift done");
        // Every selector but flush on a source: codes 1, 2, 3, 4 and 6
        wr(DCCS_OFS_TUNSEL, 8'h21);
        wr(DCCS_OFS_OSCSEL, 8'h43);
        wr(DCCS_OFS_ZPAD, 8'hEF);
        wr(DCCS_OFS_DECSEL, 8'h01);
        wr(DCCS_OFS_RATHI, 8'h20);
        tick(2);
        for (int i = 0; i < 5; i++) begin
            pulse(srcs[i], exps[i]); // source mapping
        end
        // Never ignores its source, dither included
        wr(DCCS_OFS_TUNSEL, 8'h00);
        wr(DCCS_OFS_OSCSEL, 8'h00);
        pulse(5'h10, 7'h02); // phase kept on never
        pulse(5'h02, 7'h00); // dither runs on never
        $display("test sources done");
        // Flush length follows the ratio field, here N of 8
        wr(DCCS_OFS_DECSEL, 8'h11);
        wr(DCCS_OFS_RATLO, 8'h07); // N of 8 less one
        wr(DCCS_OFS_RATHI, 8'h00);
        tick(1);
        chk(ratio, 12'h007); // ratio
        pulse(5'h10, 7'h02); // counter sync and flush on change
        meas_flush(n);
        chk(12'(n), 12'(DCCS_FLUSH_MULT * 8)); // flush length
        // Ganged mode: the same field now means N of 4
        ganged <= 1'b1;
        pulse(5'h10, 7'h02); // resync and flush again
        meas_flush(n);
        chk(12'(n), 12'(DCCS_FLUSH_MULT * 4)); // field is 2N minus one
        ganged <= 1'b0;
        $display("test flush done");
        // Sync counter period for two settings
        wait_tc(n);
        wait_tc(n);
        chk(12'(n), 12'(DCCS_TC_UNIT)); // period at setting 0
        tc_count <= 8'h01;
        wait_tc(n);
        wait_tc(n);
        wait_tc(n);
        chk(12'(n), 12'(DCCS_TC_UNIT * 2)); // period at setting 1
        // Diagnostic setting: both syncs on the counter wrap
        tc_count <= 8'h00;
        wr(DCCS_OFS_OSCSEL, 8'h55);
        wait_tc(n);
        seen = 2'b00;
        repeat (4) begin
            tick(1);
            seen = seen | {upd.osc_init, upd.dither_clr};
        end
        chk(12'(seen), 12'h003); // counter wrap drives both
        $display("test counter done");
        summarize();
    end
endmodule
`default_nettype wire
